// ==== logic/flash_seq_pkg.sv ====
// Shared constants and types for the flash sequencer link
package flash_seq_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_READY_BUSY_NS = 11000;
  localparam int T_READY_IDLE_NS = 500;
  localparam int T_RESET_HIGH_NS = 50;
  localparam int T_STANDBY_NS = 20000;
  localparam int T_PROGRAM_NS = 18000;
  localparam int T_ERASE_MS = 1000;
  localparam int T_BUSY_DELAY_NS = 90;
  localparam int T_WP_HOLD_NS = 2;
  localparam int READY_BUSY_CYC = (T_READY_BUSY_NS * 1000) / CLK_PERIOD_PS;
  localparam int READY_IDLE_CYC = (T_READY_IDLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int RESET_HIGH_CYC = (T_RESET_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STANDBY_CYC = (T_STANDBY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROGRAM_CYC = (T_PROGRAM_NS * 1000) / CLK_PERIOD_PS;
  localparam int ERASE_CYC = (T_ERASE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int BUSY_DELAY_CYC = (T_BUSY_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int WP_HOLD_CYC = (T_WP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [7:0] CMD_PROTECT = 8'h68;
  localparam logic [7:0] CMD_UNPROTECT = 8'h60;
  localparam logic [7:0] CMD_PROTECT_VERIFY = 8'h48;
  localparam logic [7:0] CMD_UNPROTECT_VERIFY = 8'h40;
  localparam logic [7:0] PROTECT_ADDR = 8'h3A;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int SECTOR_LSB = 14;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSP_BIT = 2;
  localparam int LAT_W = 4;
  localparam logic [LAT_W-1:0] BURST_LAT = 4'h4;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_WRITE = 3'b001, H_READ = 3'b011, H_WAIT = 3'b010, H_DONE = 3'b110
  } host_state_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PROGRAM = 4'h1, OP_ERASE = 4'h2, OP_PROTECT = 4'h3, OP_UNPROTECT = 4'h4
  } op_t;
endpackage

// ==== logic/flash_bus_if.sv ====
// Flash bus between memory controller and flash device
`timescale 1ns/10ps
interface flash_bus_if;
  import flash_seq_pkg::*;
  logic resetN;
  logic chipSelN;
  logic outEnN;
  logic writeEnN;
  logic writeProtN;
  logic syncRead;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hostData;
  logic [DATA_W-1:0] devData;
  logic devDataOeN;
  logic burstRdy;
  logic ready_busy_n;
  modport device (input resetN, chipSelN, outEnN, writeEnN, writeProtN, syncRead, addr, hostData,
    output devData, devDataOeN, burstRdy, ready_busy_n);
  modport host (output resetN, chipSelN, outEnN, writeEnN, writeProtN, syncRead, addr, hostData,
    input devData, devDataOeN, burstRdy, ready_busy_n);
endinterface

// ==== logic/flash_device.sv ====
// Flash device end: reset recovery, embedded status, protect sequencing
// Summary of operation
// - Reset during algorithm: ready within 11 us
// - Reset while idle: ready within 500 ns
// - Host keeps reset high 50 ns
// - Reset low 20 us enters standby
// - Protect 68h, unprotect 60h, address 3Ah
// - Verify 48h/40h reports protect result
// - Suspend toggle only inside suspended sector
// - Toggle bits advance per completed read
// - Host compares two status reads
// - Toggling stops when algorithm finishes
// - Burst ready with data or one early
// - Host waits full burst latency
// - Polling bit complemented until program done
// - Double-word program busy about 18 us
// - Sector erase busy about 1.0 s
// - Busy shown within 90 ns of write
// - Host holds write protect past ready
`timescale 1ns/10ps
module flash_device
  import flash_seq_pkg::*;
#(
  parameter int PROGRAM_CYCLES = PROGRAM_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int STANDBY_CYCLES = STANDBY_CYC,
  parameter int READY_BUSY_CYCLES = READY_BUSY_CYC,
  parameter int READY_IDLE_CYCLES = READY_IDLE_CYC,
  parameter int NUM_SECTORS = 64
) (
  input wire logic core_clk,
  input wire logic reset,
  flash_bus_if.device bus,
  input wire logic [DATA_W-1:0] arrayData,
  input wire logic readyTimingBit,
  output logic standby,
  output logic [NUM_SECTORS-1:0] sectorProtected
);
  import flash_seq_pkg::*;

  typedef struct packed {
    logic [2:0] cmdStep;
    op_t op;
    logic busy;
    logic suspended;
    logic [31:0] opCnt;
    logic [31:0] rstCnt;
    logic inReset;
    logic recovering;
    logic [31:0] recCnt;
    logic standby;
    logic [ADDR_W-1:0] opAddr;
    logic [DATA_W-1:0] opData;
    logic togglePh;
    logic suspPh;
    logic verifyMode;
    logic verifyAct;
    logic [NUM_SECTORS-1:0] prot;
    logic rdActive;
    logic [LAT_W-1:0] latCnt;
    logic [DATA_W-1:0] dout;
    logic doutOeN;
    logic rdy;
    logic rbN;
    logic weDly;
    logic csDly;
  } dev_state_t;

  dev_state_t st_r, st_nxt;

  function automatic logic [$clog2(NUM_SECTORS)-1:0] sectorOf(input logic [ADDR_W-1:0] a);
    sectorOf = a[SECTOR_LSB +: $clog2(NUM_SECTORS)];
  endfunction

  logic writeDone;
  logic readDone;
  logic readLive;
  logic [7:0] cmd;
  assign writeDone = (!st_r.weDly && bus.writeEnN && !bus.chipSelN)
    || (!st_r.csDly && bus.chipSelN && !bus.writeEnN);
  assign readLive = !bus.chipSelN && !bus.outEnN && bus.writeEnN;
  assign cmd = bus.hostData[7:0];

  always_comb begin
    logic [DATA_W-1:0] status;
    status = '0;
    st_nxt = st_r;
    st_nxt.weDly = bus.writeEnN;
    st_nxt.csDly = bus.chipSelN;
    readDone = st_r.rdActive && !readLive;
    // Hardware reset pin handling
    if (!bus.resetN) begin
      st_nxt.inReset = 1'b1;
      st_nxt.cmdStep = '0;
      st_nxt.verifyMode = 1'b0;
      st_nxt.rdActive = 1'b0;
      st_nxt.doutOeN = 1'b1;
      st_nxt.rdy = 1'b0;
      if (!st_r.inReset) begin
        st_nxt.recovering = 1'b1;
        st_nxt.recCnt = st_r.busy ? 32'(READY_BUSY_CYCLES - 1) : 32'(READY_IDLE_CYCLES - 1);
        st_nxt.rstCnt = 32'h0000_0000;
      end else if (st_r.rstCnt < 32'(STANDBY_CYCLES)) begin
        st_nxt.rstCnt = st_r.rstCnt + 32'h0000_0001;
      end
      if (st_r.rstCnt + 32'h0000_0001 >= 32'(STANDBY_CYCLES)) begin
        st_nxt.standby = 1'b1;
      end
      if (st_r.recovering) begin
        if (st_r.recCnt == 32'h0000_0000) begin
          st_nxt.recovering = 1'b0;
        end else begin
          st_nxt.recCnt = st_r.recCnt - 32'h0000_0001;
        end
        if (st_r.busy && st_r.recCnt == 32'h0000_0000) begin
          st_nxt.busy = 1'b0;
          st_nxt.op = OP_NONE;
          st_nxt.suspended = 1'b0;
        end
      end
      st_nxt.rbN = !st_nxt.busy;
    end else begin
      st_nxt.inReset = 1'b0;
      st_nxt.standby = 1'b0;
      st_nxt.rstCnt = 32'h0000_0000;
      if (st_r.recovering) begin
        // Finish recovery after release; accesses ignored meanwhile
        if (st_r.recCnt == 32'h0000_0000) begin
          st_nxt.recovering = 1'b0;
          if (st_r.busy) begin
            st_nxt.busy = 1'b0;
            st_nxt.op = OP_NONE;
            st_nxt.suspended = 1'b0;
          end
        end else begin
          st_nxt.recCnt = st_r.recCnt - 32'h0000_0001;
        end
      end else begin
        // Embedded algorithm timer
        if (st_r.busy && !st_r.suspended) begin
          if (st_r.opCnt == 32'h0000_0000) begin
            st_nxt.busy = 1'b0;
            if (st_r.op == OP_PROTECT) begin
              st_nxt.prot[sectorOf(st_r.opAddr)] = 1'b1;
            end else if (st_r.op == OP_UNPROTECT) begin
              st_nxt.prot[sectorOf(st_r.opAddr)] = 1'b0;
            end
          end else begin
            st_nxt.opCnt = st_r.opCnt - 32'h0000_0001;
          end
        end
        // Command decoder on write completion
        if (writeDone) begin
          st_nxt.verifyMode = 1'b0;
          if (cmd == CMD_READ_RESET && st_r.cmdStep != 3'h3) begin
            st_nxt.cmdStep = '0;
          end else if (st_r.busy && cmd == CMD_SUSPEND && st_r.op == OP_ERASE) begin
            st_nxt.suspended = 1'b1;
          end else if (st_r.busy && st_r.suspended && cmd == CMD_RESUME) begin
            st_nxt.suspended = 1'b0;
          end else if (!st_r.busy && st_r.cmdStep != 3'h3 && bus.addr[7:0] == PROTECT_ADDR
                       && (cmd == CMD_PROTECT || cmd == CMD_UNPROTECT)) begin
            st_nxt.busy = 1'b1;
            st_nxt.op = (cmd == CMD_PROTECT) ? OP_PROTECT : OP_UNPROTECT;
            st_nxt.opAddr = bus.addr;
            st_nxt.opCnt = 32'(PROGRAM_CYCLES - 1);
            st_nxt.cmdStep = '0;
          end else if (!st_r.busy && st_r.cmdStep != 3'h3 && bus.addr[7:0] == PROTECT_ADDR
                       && (cmd == CMD_PROTECT_VERIFY || cmd == CMD_UNPROTECT_VERIFY)) begin
            st_nxt.verifyMode = 1'b1;
            st_nxt.verifyAct = (cmd == CMD_PROTECT_VERIFY);
            st_nxt.opAddr = bus.addr;
          end else if (!st_r.busy) begin
            case (st_r.cmdStep)
              3'h0: st_nxt.cmdStep = (cmd == CMD_UNLOCK1) ? 3'h1 : 3'h0;
              3'h1: st_nxt.cmdStep = (cmd == CMD_UNLOCK2) ? 3'h2 : 3'h0;
              3'h2: begin
                st_nxt.cmdStep = (cmd == CMD_PROGRAM) ? 3'h3 : (cmd == CMD_ERASE_SETUP) ? 3'h4 : 3'h0;
              end
              3'h3: begin
                st_nxt.busy = 1'b1;
                st_nxt.op = OP_PROGRAM;
                st_nxt.opAddr = bus.addr;
                st_nxt.opData = bus.hostData;
                st_nxt.opCnt = 32'(PROGRAM_CYCLES - 1);
                st_nxt.cmdStep = '0;
              end
              3'h4: st_nxt.cmdStep = (cmd == CMD_UNLOCK1) ? 3'h5 : 3'h0;
              3'h5: st_nxt.cmdStep = (cmd == CMD_UNLOCK2) ? 3'h6 : 3'h0;
              3'h6: begin
                if (cmd == CMD_SECTOR_ERASE) begin
                  st_nxt.busy = 1'b1;
                  st_nxt.op = OP_ERASE;
                  st_nxt.opAddr = bus.addr;
                  st_nxt.opData = '1;
                  st_nxt.opCnt = 32'(ERASE_CYCLES - 1);
                end
                st_nxt.cmdStep = '0;
              end
              default: st_nxt.cmdStep = '0;
            endcase
          end
        end
        // Read path and toggles
        st_nxt.rdActive = readLive;
        if (readDone && st_r.busy) begin
          st_nxt.togglePh = !st_r.togglePh;
          if (st_r.suspended && sectorOf(bus.addr) == sectorOf(st_r.opAddr)) begin
            st_nxt.suspPh = !st_r.suspPh;
          end
        end
        if (st_r.busy && !(st_r.suspended && sectorOf(bus.addr) != sectorOf(st_r.opAddr))) begin
          status[POLL_BIT] = (st_r.op == OP_PROGRAM) ? !st_r.opData[POLL_BIT] : 1'b0;
          status[TOGGLE_BIT] = st_r.togglePh;
          status[SUSP_BIT] = st_r.suspPh;
        end else if (st_r.verifyMode) begin
          status = {{(DATA_W-1){1'b0}}, st_r.prot[sectorOf(st_r.opAddr)] == st_r.verifyAct};
        end else if (!st_r.busy && st_r.op == OP_PROGRAM && bus.addr == st_r.opAddr) begin
          status = st_r.opData;
        end else begin
          status = arrayData;
        end
        if (!readLive) begin
          st_nxt.latCnt = '0;
          st_nxt.rdy = 1'b0;
          st_nxt.doutOeN = 1'b1;
        end else if (!bus.syncRead) begin
          st_nxt.dout = status;
          st_nxt.doutOeN = 1'b0;
        end else begin
          if (st_r.latCnt != BURST_LAT) begin
            st_nxt.latCnt = st_r.latCnt + 4'h1;
          end
          if (st_nxt.latCnt == BURST_LAT) begin
            st_nxt.dout = status;
            st_nxt.doutOeN = 1'b0;
          end
          st_nxt.rdy = readyTimingBit ? (st_nxt.latCnt >= BURST_LAT - 4'h1) : (st_nxt.latCnt == BURST_LAT);
        end
      end
      st_nxt.rbN = !st_nxt.busy;
    end
    if (reset) begin
      st_nxt = '0;
      st_nxt.doutOeN = 1'b1;
      st_nxt.rbN = 1'b1;
      st_nxt.weDly = 1'b1;
      st_nxt.csDly = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  assign bus.devData = st_r.dout;
  assign bus.devDataOeN = st_r.doutOeN;
  assign bus.burstRdy = st_r.rdy;
  assign bus.ready_busy_n = st_r.rbN;
  assign standby = st_r.standby;
  assign sectorProtected = st_r.prot;
endmodule // flash_device

// ==== logic/flash_host.sv ====
// Memory controller end: bus cycles, reset pin and status polling
`timescale 1ns/10ps
module flash_host
  import flash_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  flash_bus_if.host bus,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqSync,
  input wire logic reqPoll,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  input wire logic flashResetReq,
  input wire logic writeProtReq,
  output logic reqReady,
  output logic respValid,
  output logic [DATA_W-1:0] respData,
  output logic opRunning
);
  import flash_seq_pkg::*;

  typedef struct packed {
    host_state_t state;
    logic [7:0] cnt;
    logic [7:0] rstHighCnt;
    logic resetN;
    logic csN;
    logic oeN;
    logic weN;
    logic wpN;
    logic sync;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic poll;
    logic second;
    logic [DATA_W-1:0] first;
    logic rdy;
    logic rv;
    logic [DATA_W-1:0] rd;
    logic running;
    logic [7:0] wpHold;
  } host_st_t;

  host_st_t h_r, h_nxt;

  always_comb begin
    h_nxt = h_r;
    h_nxt.rv = 1'b0;
    h_nxt.resetN = !flashResetReq;
    if (!h_r.resetN) begin
      h_nxt.rstHighCnt = '0;
    end else if (h_r.rstHighCnt < 8'(RESET_HIGH_CYC)) begin
      h_nxt.rstHighCnt = h_r.rstHighCnt + 8'h01;
    end
    // Write protect changes only after ready is held long enough
    if (!bus.ready_busy_n) begin
      h_nxt.wpHold = '0;
    end else if (h_r.wpHold < 8'(WP_HOLD_CYC)) begin
      h_nxt.wpHold = h_r.wpHold + 8'h01;
    end
    if (h_r.wpHold >= 8'(WP_HOLD_CYC) && bus.ready_busy_n) begin
      h_nxt.wpN = !writeProtReq;
    end
    case (h_r.state)
      H_IDLE: begin
        h_nxt.rdy = h_r.resetN && h_r.rstHighCnt >= 8'(RESET_HIGH_CYC);
        if (reqValid && h_r.rdy) begin
          h_nxt.rdy = 1'b0;
          h_nxt.addr = reqAddr;
          h_nxt.data = reqData;
          h_nxt.sync = reqSync;
          h_nxt.poll = reqPoll;
          h_nxt.second = 1'b0;
          h_nxt.csN = 1'b0;
          h_nxt.cnt = '0;
          h_nxt.weN = !reqWrite;
          h_nxt.oeN = reqWrite;
          h_nxt.state = reqWrite ? H_WRITE : H_READ;
        end
      end
      H_WRITE: begin
        h_nxt.cnt = h_r.cnt + 8'h01;
        if (h_r.cnt == 8'h05) begin
          h_nxt.weN = 1'b1;
          h_nxt.state = H_DONE;
        end
      end
      H_READ: begin
        h_nxt.cnt = h_r.cnt + 8'h01;
        if ((!h_r.sync && h_r.cnt == 8'h04) || (h_r.sync && bus.burstRdy && !bus.devDataOeN)) begin
          h_nxt.oeN = 1'b1;
          h_nxt.csN = 1'b1;
          if (h_r.poll && !h_r.second) begin
            h_nxt.first = bus.devData;
            h_nxt.second = 1'b1;
            h_nxt.state = H_WAIT;
          end else begin
            h_nxt.rd = bus.devData;
            h_nxt.running = h_r.poll && (bus.devData[TOGGLE_BIT] != h_r.first[TOGGLE_BIT]);
            h_nxt.state = H_DONE;
          end
        end else if (h_r.cnt == 8'hFF) begin
          h_nxt.oeN = 1'b1;
          h_nxt.csN = 1'b1;
          h_nxt.state = H_DONE;
        end
      end
      H_WAIT: begin
        h_nxt.csN = 1'b0;
        h_nxt.oeN = 1'b0;
        h_nxt.cnt = '0;
        h_nxt.state = H_READ;
      end
      H_DONE: begin
        h_nxt.csN = 1'b1;
        h_nxt.rv = 1'b1;
        h_nxt.state = H_IDLE;
      end
      default: h_nxt.state = H_IDLE;
    endcase
    if (!h_r.resetN && h_r.state != H_IDLE) begin
      h_nxt.state = H_IDLE;
      h_nxt.csN = 1'b1;
      h_nxt.oeN = 1'b1;
      h_nxt.weN = 1'b1;
    end
    if (reset) begin
      h_nxt = '0;
      h_nxt.state = H_IDLE;
      h_nxt.resetN = 1'b1;
      h_nxt.csN = 1'b1;
      h_nxt.oeN = 1'b1;
      h_nxt.weN = 1'b1;
      h_nxt.wpN = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    h_r <= h_nxt;
  end

  assign bus.resetN = h_r.resetN;
  assign bus.chipSelN = h_r.csN;
  assign bus.outEnN = h_r.oeN;
  assign bus.writeEnN = h_r.weN;
  assign bus.writeProtN = h_r.wpN;
  assign bus.syncRead = h_r.sync;
  assign bus.addr = h_r.addr;
  assign bus.hostData = h_r.data;
  assign reqReady = h_r.rdy;
  assign respValid = h_r.rv;
  assign respData = h_r.rd;
  assign opRunning = h_r.running;
endmodule // flash_host

// ==== bench/flash_link_chk.sv ====
// Concurrent checks on the flash bus between host and device
`timescale 1ns/10ps
module flash_link_chk
  import flash_seq_pkg::*;
#(
  parameter int PROG_LEN = 20,
  parameter int ERASE_LEN = 40,
  parameter int RECOV_MAX = 30
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic resetN,
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeEnN,
  input wire logic writeProtN,
  input wire logic syncRead,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] hostData,
  input wire logic [DATA_W-1:0] devData,
  input wire logic devDataOeN,
  input wire logic burstRdy,
  input wire logic ready_busy_n,
  input wire logic readyTimingBit
);
  typedef struct packed {
    logic [7:0] weAge;
    logic [15:0] rstHigh;
    logic [15:0] busyAge;
    logic prevOe;
    logic prevCs;
    logic prevWe;
    logic curTog;
    logic prevTog;
    logic haveTog;
    logic susp;
  } chk_state_t;
  chk_state_t st_r;
  chk_state_t st_nxt;
  logic rdEnd;
  assign rdEnd = !st_r.prevOe && !st_r.prevCs && (outEnN || chipSelN);
  always_comb begin
    st_nxt = st_r;
    st_nxt.prevOe = outEnN;
    st_nxt.prevCs = chipSelN;
    st_nxt.prevWe = writeEnN;
    if (writeEnN && !st_r.prevWe) begin
      st_nxt.weAge = 8'h00;
    end else if (st_r.weAge != 8'hFF) begin
      st_nxt.weAge = st_r.weAge + 8'h01;
    end
    if (!resetN) begin
      st_nxt.rstHigh = 16'h0000;
    end else if (st_r.rstHigh != 16'hFFFF) begin
      st_nxt.rstHigh = st_r.rstHigh + 16'h0001;
    end
    // Erase suspend pauses the busy age
    if (writeEnN && !st_r.prevWe && !ready_busy_n) begin
      if (hostData[7:0] == CMD_SUSPEND) begin
        st_nxt.susp = 1'b1;
      end else if (hostData[7:0] == CMD_RESUME) begin
        st_nxt.susp = 1'b0;
      end
    end
    if (ready_busy_n) begin
      st_nxt.susp = 1'b0;
    end
    st_nxt.busyAge = ready_busy_n ? 16'h0000 : st_r.susp ? st_r.busyAge : st_r.busyAge + 16'h0001;
    if (!outEnN && !devDataOeN) begin
      st_nxt.curTog = devData[TOGGLE_BIT];
    end
    if (rdEnd) begin
      st_nxt.prevTog = st_r.curTog;
      st_nxt.haveTog = !ready_busy_n && resetN;
    end
    // Strobe history starts at idle level
    if (reset) begin
      st_nxt = '0;
      st_nxt.prevOe = 1'b1;
      st_nxt.prevCs = 1'b1;
      st_nxt.prevWe = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  busy_after_write_a: assert property (
    $fell(ready_busy_n) && resetN |-> st_r.weAge <= 8'(BUSY_DELAY_CYC))
    else $error("busy came too late after write edge");
  recovery_bound_a: assert property (
    $rose(resetN) |-> ##[0:RECOV_MAX] ready_busy_n)
    else $error("device not ready after reset pin");
  reset_gap_a: assert property (
    $fell(outEnN) |-> st_r.rstHigh >= 16'(RESET_HIGH_CYC - 1))
    else $error("read begun too soon after reset pin");
  ready_with_data_a: assert property (
    burstRdy && !readyTimingBit |-> !devDataOeN)
    else $error("burst ready without data");
  ready_early_a: assert property (
    $rose(burstRdy) && readyTimingBit |=> !devDataOeN)
    else $error("early burst ready not followed by data");
  wp_hold_a: assert property (
    !$past(ready_busy_n) |-> $stable(writeProtN))
    else $error("write protect moved while busy");
  toggle_step_a: assert property (
    rdEnd && !ready_busy_n && st_r.haveTog |-> st_r.curTog != st_r.prevTog)
    else $error("toggle bit did not advance");
  protect_busy_a: assert property (
    $rose(writeEnN) && ready_busy_n && st_r.rstHigh > 16'(RECOV_MAX) && addr[7:0] == PROTECT_ADDR
    && (hostData[7:0] == CMD_PROTECT || hostData[7:0] == CMD_UNPROTECT) |-> ##[1:2] !ready_busy_n)
    else $error("protect command did not start");
  busy_len_a: assert property (
    $rose(ready_busy_n) && st_r.rstHigh > st_r.busyAge
    |-> st_r.busyAge >= 16'(PROG_LEN - 1) && st_r.busyAge <= 16'(ERASE_LEN + 1))
    else $error("busy length out of range");
  cover property ($fell(outEnN) && syncRead);
  cover property ($rose(burstRdy) && readyTimingBit);
  cover property (rdEnd && !ready_busy_n && st_r.haveTog);
  cover property ($rose(ready_busy_n));
endmodule // flash_link_chk

// ==== bench/flash_reset_status_protect_tb.sv ====
// Self-checking bench joining the host and device ends
`timescale 1ns/10ps
module flash_reset_status_protect_tb;
  import flash_seq_pkg::*;
  localparam int PROG = 200;
  localparam int ERASE = 400;
  localparam int STBY = 50;
  localparam int RBUSY = 30;
  localparam int RIDLE = 5;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqSync = 1'b0, reqPoll = 1'b0;
  logic [ADDR_W-1:0] reqAddr = '0, a;
  logic [DATA_W-1:0] reqData = '0, arrayData = '0, d, respData;
  logic flashResetReq = 1'b0, writeProtReq = 1'b0, readyTimingBit = 1'b0;
  logic reqReady, respValid, opRunning, standby;
  logic [63:0] sectorProtected;
  logic [DATA_W-1:0] expMask[$], expVal[$];
  int bad_count = 0, samples_checked = 0, seed = 77788;
  always #2.5 core_clk = ~core_clk;
  flash_bus_if u_flash_bus_if ();
  flash_device #(.PROGRAM_CYCLES(PROG), .ERASE_CYCLES(ERASE), .STANDBY_CYCLES(STBY),
    .READY_BUSY_CYCLES(RBUSY), .READY_IDLE_CYCLES(RIDLE)) u_flash_device (.core_clk(core_clk),
    .reset(reset), .bus(u_flash_bus_if.device), .arrayData(arrayData), .readyTimingBit(readyTimingBit),
    .standby(standby), .sectorProtected(sectorProtected));
  flash_host u_flash_host (.core_clk(core_clk), .reset(reset), .bus(u_flash_bus_if.host), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqSync(reqSync), .reqPoll(reqPoll), .reqAddr(reqAddr), .reqData(reqData),
    .flashResetReq(flashResetReq), .writeProtReq(writeProtReq), .reqReady(reqReady), .respValid(respValid),
    .respData(respData), .opRunning(opRunning));
  flash_link_chk #(.PROG_LEN(PROG), .ERASE_LEN(ERASE), .RECOV_MAX(RBUSY)) u_flash_link_chk (.core_clk(core_clk),
    .reset(reset), .resetN(u_flash_bus_if.resetN), .chipSelN(u_flash_bus_if.chipSelN),
    .outEnN(u_flash_bus_if.outEnN), .writeEnN(u_flash_bus_if.writeEnN), .writeProtN(u_flash_bus_if.writeProtN),
    .syncRead(u_flash_bus_if.syncRead), .addr(u_flash_bus_if.addr), .hostData(u_flash_bus_if.hostData),
    .devData(u_flash_bus_if.devData), .devDataOeN(u_flash_bus_if.devDataOeN), .burstRdy(u_flash_bus_if.burstRdy),
    .ready_busy_n(u_flash_bus_if.ready_busy_n), .readyTimingBit(readyTimingBit));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_for(input logic sel, input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge core_clk);
      if ((sel ? (reqReady & ~respValid) : u_flash_bus_if.ready_busy_n) === lvl) break;
    end
    if (n == lim) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask
  task automatic xfer(input logic w, input logic s, input logic p, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] dt, input logic [DATA_W-1:0] mk, input logic [DATA_W-1:0] ev);
    wait_for(1'b1, 1'b1, 500);
    if (mk != '0) begin
      expMask.push_back(mk);
      expVal.push_back(ev);
    end
    reqValid = 1'b1;
    reqWrite = w;
    reqSync = s;
    reqPoll = p;
    reqAddr = ad;
    reqData = dt;
    @(negedge core_clk);
    reqValid = 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [7:0] v);
    xfer(1'b1, 1'b0, 1'b0, ad, {24'h0, v}, '0, '0);
  endtask
  task automatic unlock(input logic [ADDR_W-1:0] ad);
    wr(ad, CMD_UNLOCK1);
    wr(ad, CMD_UNLOCK2);
  endtask
  task automatic poll(input logic [ADDR_W-1:0] ad, input logic exp);
    xfer(1'b0, 1'b0, 1'b1, ad, '0, '0, '0);
    wait_for(1'b1, 1'b1, 500);
    chk(32'(opRunning), 32'(exp));
  endtask
  task automatic pin_reset(input int len);
    flashResetReq = 1'b1;
    repeat (len) @(negedge core_clk);
    flashResetReq = 1'b0;
  endtask
  always @(negedge core_clk) begin
    if (respValid === 1'b1 && expVal.size() > 0) begin
      chk(respData & expMask[0], expVal[0] & expMask[0]);
      void'(expMask.pop_front());
      void'(expVal.pop_front());
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    // Array reads, async and sync, both ready timings
    for (int i = 0; i < 4; i++) begin
      wait_for(1'b1, 1'b1, 500);
      readyTimingBit = i[1];
      arrayData = $random(seed);
      a = ADDR_W'($random(seed));
      xfer(1'b0, i[0], 1'b0, a, '0, '1, arrayData);
    end
    // Protect then unprotect, each verified
    for (int i = 0; i < 2; i++) begin
      a = ADDR_W'($random(seed));
      a[7:0] = PROTECT_ADDR;
      wr(a, i[0] ? CMD_UNPROTECT : CMD_PROTECT);
      wait_for(1'b0, 1'b0, 12);
      wait_for(1'b0, 1'b1, PROG + 20);
      chk(32'(sectorProtected[a[ADDR_W-1:SECTOR_LSB]]), 32'(!i[0]));
      wr(a, i[0] ? CMD_UNPROTECT_VERIFY : CMD_PROTECT_VERIFY);
      xfer(1'b0, 1'b0, 1'b0, a, '0, 32'h1, 32'h1);
    end
    // Program with status polling
    d = $random(seed);
    a = ADDR_W'($random(seed));
    unlock(a);
    wr(a, CMD_PROGRAM);
    xfer(1'b1, 1'b0, 1'b0, a, d, '0, '0);
    wait_for(1'b0, 1'b0, 12);
    xfer(1'b0, 1'b0, 1'b0, a, '0, 32'h80, ~d);
    poll(a, 1'b1);
    wait_for(1'b0, 1'b1, PROG + 20);
    poll(a, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, a, '0, '1, d);
    // Sector erase
    unlock(a);
    wr(a, CMD_ERASE_SETUP);
    unlock(a);
    wr(a, CMD_SECTOR_ERASE);
    wait_for(1'b0, 1'b0, 12);
    xfer(1'b0, 1'b0, 1'b0, a, '0, 32'h80, 32'h0);
    poll(a, 1'b1);
    wr(a, CMD_SUSPEND);
    xfer(1'b0, 1'b0, 1'b0, a, '0, 32'h4, 32'h0);
    xfer(1'b0, 1'b0, 1'b0, a, '0, 32'h4, 32'h4);
    wr(a, CMD_RESUME);
    writeProtReq = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(32'(u_flash_bus_if.writeProtN), 32'h1);
    wait_for(1'b0, 1'b1, ERASE + 20);
    repeat (4) @(negedge core_clk);
    chk(32'(u_flash_bus_if.writeProtN), 32'h0);
    writeProtReq = 1'b0;
    // Reset during program, then partial sequence dropped
    unlock(a);
    wr(a, CMD_PROGRAM);
    xfer(1'b1, 1'b0, 1'b0, a, d, '0, '0);
    wait_for(1'b0, 1'b0, 12);
    pin_reset(10);
    wait_for(1'b0, 1'b1, RBUSY + 15);
    wr(a, CMD_UNLOCK1);
    wait_for(1'b1, 1'b1, 500);
    pin_reset(10);
    wait_for(1'b0, 1'b1, RIDLE + 15);
    wr(a, CMD_UNLOCK2);
    wr(a, CMD_PROGRAM);
    xfer(1'b1, 1'b0, 1'b0, a, d, '0, '0);
    repeat (12) @(negedge core_clk);
    chk(32'(u_flash_bus_if.ready_busy_n), 32'h1);
    arrayData = $random(seed);
    xfer(1'b0, 1'b0, 1'b0, a, '0, '1, arrayData);
    // Long reset low reaches standby
    wait_for(1'b1, 1'b1, 500);
    flashResetReq = 1'b1;
    repeat (STBY - 10) @(negedge core_clk);
    chk(32'(standby), 32'h0);
    repeat (15) @(negedge core_clk);
    chk(32'(standby), 32'h1);
    flashResetReq = 1'b0;
    xfer(1'b0, 1'b1, 1'b0, a, '0, '1, arrayData);
    wait_for(1'b1, 1'b1, 500);
    chk(32'(expVal.size()), 32'h0);
    end_sim();
  end
endmodule // flash_reset_status_protect_tb
